/* File: src/frx_pkg.sv */
// constants and encodings for the fp result conditioning and exception block
package frx_pkg;
    // operation codes, anything above OP_STORE is undefined
    localparam logic [3:0] OP_ADD = 4'h0;
    localparam logic [3:0] OP_SUB = 4'h1;
    localparam logic [3:0] OP_MUL = 4'h2;
    localparam logic [3:0] OP_DIV = 4'h3;
    localparam logic [3:0] OP_CMP = 4'h4;
    localparam logic [3:0] OP_I2F = 4'h5;
    localparam logic [3:0] OP_F2I = 4'h6;
    localparam logic [3:0] OP_STORE = 4'h7;
    // rounding modes
    localparam logic [1:0] ROUND_NEAREST_EVEN = 2'h0;
    localparam logic [1:0] ROUND_TOWARD_ZERO = 2'h1;
    localparam logic [1:0] ROUND_TOWARD_PLUS = 2'h2;
    localparam logic [1:0] ROUND_TOWARD_MINUS = 2'h3;
    // operand classes
    localparam logic [2:0] CL_ZERO = 3'h0;
    localparam logic [2:0] CL_DENORMAL = 3'h1;
    localparam logic [2:0] CL_NORMAL = 3'h2;
    localparam logic [2:0] CL_INFINITY = 3'h3;
    localparam logic [2:0] CL_NAN = 3'h4;
    // exception flag bit positions
    localparam int NFLAG = 6;
    localparam int FLG_INEXACT = 0;
    localparam int FLG_UNDERFLOW = 1;
    localparam int FLG_OVERFLOW = 2;
    localparam int FLG_DIV0 = 3;
    localparam int FLG_INVALID = 4;
    localparam int FLG_UNDEF = 5;
    // compare condition codes
    localparam logic [1:0] CC_EQ = 2'h0;
    localparam logic [1:0] CC_LT = 2'h1;
    localparam logic [1:0] CC_GT = 2'h2;
    localparam logic [1:0] CC_UNORD = 2'h3;
    // register map and control register fields
    localparam logic [3:0] REG_PROC_CTRL = 4'h0;
    localparam logic [3:0] REG_RES_LO = 4'h4;
    localparam logic [3:0] REG_RES_HI = 4'h8;
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_EN_LSB = 8;
    localparam int CTL_CC_LSB = 16;
    localparam int CTL_ACC_LSB = 24;
    // format constants
    localparam logic [12:0] SGL_EMAX = 13'h0ff;
    localparam logic [12:0] DBL_EMAX = 13'h7ff;
    localparam logic [12:0] SGL_BIAS = 13'h07f;
    localparam logic [12:0] DBL_BIAS = 13'h3ff;
    localparam logic [12:0] EXP_ONE = 13'h001;
    localparam logic signed [12:0] EXP_MIN = 13'sh001;
    localparam logic [63:0] SGL_NAN = 64'h0000_0000_7fff_ffff;
    localparam logic [63:0] DBL_NAN = 64'h7fff_ffff_ffff_ffff;
    // integer conversion constants
    localparam int INT_W = 32;
    localparam logic [12:0] INT_TOP = 13'h01f;
    localparam logic signed [12:0] FRAC_TOP = 13'sh034;
    localparam logic signed [12:0] F2I_TOP = 13'sh01f;
    localparam logic signed [12:0] F2I_LOW = -13'sh001;
    localparam logic [33:0] INT_POS_LIM = 34'h0_7fff_ffff;
    localparam logic [33:0] INT_NEG_LIM = 34'h0_8000_0000;
    localparam logic [31:0] INT_MAX = 32'h7fff_ffff;
    localparam logic [31:0] INT_MIN = 32'h8000_0000;
endpackage

/* File: src/frx_round_except.sv */
// fp result conditioning: classify, special cases, rounding, exception flags
// Behaviour
// - max exponent, nonzero fraction is NaN
// - zero exponent, nonzero fraction is denormal
// - four rounding modes govern rounded results
// - nearest rounding, ties go to even
// - toward zero rounding truncates magnitude
// - toward plus rounds up to greater
// - toward minus rounds down to lesser
// - enabled exception raises the interrupt
// - illegal opcode or non-store read flags undefined
// - lost low bits set inexact flag
// - overflow gives largest finite or infinity by mode
// - float to int overflow flags overflow
// - tiny nonzero result underflows to zero
// - normal over zero gives signed infinity
// - NaN or invalid add, sub, mul or div gives positive NaN
// - denormal inputs and outputs flush to zero
// - zero sum sign rule, minus mode negative
// - add sub infinity cases
// - divide special cases
// - compare gives unordered, equal, less, greater
// - int to double is exact
// - int to single rounds, inexact flagged
// - max exponent, zero fraction is infinity
// - exponents inside range are normalized
`timescale 1ns/100ps
module frx_round_except (
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // instruction issue
    input wire logic issue_in,
    input wire logic [3:0] op_in,
    input wire logic prec_in,
    input wire logic read_cycle_in,
    input wire logic [63:0] a_in,
    input wire logic [63:0] b_in,
    // unrounded datapath result
    input wire logic raw_sign_in,
    input wire logic signed [12:0] raw_exp_in,
    input wire logic [55:0] raw_sig_in,
    input wire logic raw_zero_in,
    // conditioned result
    output logic done_out,
    output logic [63:0] result_out,
    output logic [5:0] op_flags_out,
    output logic [1:0] cond_code_out,
    output logic exc_irq_out,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out
);
    function automatic logic [10:0] fexp(input logic p, input logic [63:0] x);
        return p ? x[62:52] : {3'h0, x[30:23]};
    endfunction

    function automatic logic [51:0] ffrac(input logic p, input logic [63:0] x);
        return p ? x[51:0] : {x[22:0], 29'h0};
    endfunction

    function automatic logic [12:0] emax(input logic p);
        return p ? frx_pkg::DBL_EMAX : frx_pkg::SGL_EMAX;
    endfunction

    function automatic logic [12:0] bias(input logic p);
        return p ? frx_pkg::DBL_BIAS : frx_pkg::SGL_BIAS;
    endfunction

    function automatic logic [2:0] fcls(input logic p, input logic [63:0] x);
        logic [12:0] e;
        logic nz;
        e = {2'h0, fexp(p, x)};
        nz = |ffrac(p, x);
        if (e == emax(p))
            return nz ? frx_pkg::CL_NAN : frx_pkg::CL_INFINITY;
        if (e == '0)
            return nz ? frx_pkg::CL_DENORMAL : frx_pkg::CL_ZERO;
        return frx_pkg::CL_NORMAL;
    endfunction

    function automatic logic [63:0] pack(input logic p, input logic s, input logic [12:0] e,
                                         input logic [51:0] f);
        return p ? {s, e[10:0], f} : {32'h0, s, e[7:0], f[51:29]};
    endfunction

    function automatic logic [63:0] infinity(input logic p, input logic s);
        return pack(p, s, emax(p), '0);
    endfunction

    function automatic logic [63:0] nan_val(input logic p);
        return p ? frx_pkg::DBL_NAN : frx_pkg::SGL_NAN;
    endfunction

    function automatic logic rnd_up(input logic [1:0] m, input logic s, lsb, g, st);
        logic r;
        r = 1'b0;
        case (m)
            frx_pkg::ROUND_NEAREST_EVEN: r = g & (st | lsb);
            frx_pkg::ROUND_TOWARD_ZERO: r = 1'b0;
            frx_pkg::ROUND_TOWARD_PLUS: r = ~s & (g | st);
            frx_pkg::ROUND_TOWARD_MINUS: r = s & (g | st);
        endcase
        return r;
    endfunction

    function automatic logic [4:0] lzc32(input logic [31:0] x);
        logic [4:0] n;
        n = 5'h0;
        for (int i = 0; i < frx_pkg::INT_W; i++) begin
            if (x[i]) begin
                n = 5'(frx_pkg::INT_W - 1 - i);
            end
        end
        return n;
    endfunction

    // signs are ignored on zero so that +0 and -0 compare equal
    function automatic logic [1:0] fcmp(input logic sa, sb, input logic [62:0] ma, mb);
        logic xa;
        logic xb;
        xa = sa & (|ma);
        xb = sb & (|mb);
        if (xa != xb)
            return xa ? frx_pkg::CC_LT : frx_pkg::CC_GT;
        if (ma == mb)
            return frx_pkg::CC_EQ;
        return ((ma > mb) ^ xa) ? frx_pkg::CC_GT : frx_pkg::CC_LT;
    endfunction

    logic [1:0] mode_reg;
    logic [5:0] en_reg;
    logic [5:0] acc_reg;
    logic [5:0] acc_next;
    logic [1:0] cc_reg;
    logic [63:0] res_reg;
    logic [5:0] flg_reg;
    logic done_reg;
    logic [31:0] rdata_reg;
    logic ctl_wr;

    // operand classification
    logic [2:0] ca;
    logic [2:0] cb;
    logic sa;
    logic sb;
    logic sbe;
    logic sx;
    logic za;
    logic zb;
    logic nan_any;
    always_comb begin
        ca = fcls(prec_in, a_in);
        cb = fcls(prec_in, b_in);
        sa = prec_in ? a_in[63] : a_in[31];
        sb = prec_in ? b_in[63] : b_in[31];
        sbe = sb ^ (op_in == frx_pkg::OP_SUB);
        sx = sa ^ sb;
        za = (ca == frx_pkg::CL_ZERO) || (ca == frx_pkg::CL_DENORMAL);
        zb = (cb == frx_pkg::CL_ZERO) || (cb == frx_pkg::CL_DENORMAL);
        nan_any = (ca == frx_pkg::CL_NAN) || (cb == frx_pkg::CL_NAN);
    end

    // source of the value to round: datapath, or integer normaliser
    logic [31:0] i_mag;
    logic [4:0] i_lz;
    logic r_s;
    logic signed [12:0] r_e;
    logic [55:0] r_sig;
    logic r_z;
    always_comb begin
        i_mag = a_in[31] ? (~a_in[31:0] + 32'h1) : a_in[31:0];
        i_lz = lzc32(i_mag);
        if (op_in == frx_pkg::OP_I2F) begin
            r_s = a_in[31];
            r_e = bias(prec_in) + frx_pkg::INT_TOP - 13'(i_lz);
            r_sig = {i_mag << i_lz, 24'h0};
            r_z = ~|a_in[31:0];
        end else begin
            r_s = raw_sign_in;
            r_e = raw_exp_in;
            r_sig = raw_sig_in;
            r_z = raw_zero_in;
        end
    end

    // shared rounder; a 32-bit integer always fits a double exactly
    logic [52:0] k_sig;
    logic g_bit;
    logic st_bit;
    logic [53:0] sum;
    logic cy;
    logic signed [12:0] e_r;
    logic to_max;
    logic [63:0] rnd_val;
    logic [5:0] rnd_flg;
    always_comb begin
        k_sig = prec_in ? r_sig[55:3] : {29'h0, r_sig[55:32]};
        g_bit = prec_in ? r_sig[2] : r_sig[31];
        st_bit = prec_in ? |r_sig[1:0] : |r_sig[30:0];
        sum = {1'b0, k_sig} + 54'(rnd_up(mode_reg, r_s, k_sig[0], g_bit, st_bit));
        cy = prec_in ? sum[53] : sum[24];
        e_r = r_e + 13'(cy);
        to_max = (mode_reg == frx_pkg::ROUND_TOWARD_ZERO) ||
                 (mode_reg == frx_pkg::ROUND_TOWARD_MINUS && !r_s) ||
                 (mode_reg == frx_pkg::ROUND_TOWARD_PLUS && r_s);
        rnd_flg = '0;
        rnd_flg[frx_pkg::FLG_INEXACT] = g_bit | st_bit;
        if (r_z) begin
            rnd_val = pack(prec_in, r_s, '0, '0);
        end else if (e_r >= $signed(emax(prec_in))) begin
            rnd_flg[frx_pkg::FLG_OVERFLOW] = 1'b1;
            rnd_flg[frx_pkg::FLG_INEXACT] = 1'b1;
            rnd_val = to_max ? pack(prec_in, r_s, emax(prec_in) - frx_pkg::EXP_ONE, '1)
                             : infinity(prec_in, r_s);
        end else if (e_r < frx_pkg::EXP_MIN) begin
            rnd_flg[frx_pkg::FLG_UNDERFLOW] = 1'b1;
            rnd_val = pack(prec_in, r_s, '0, '0);
        end else begin
            rnd_val = pack(prec_in, r_s, e_r, prec_in ? sum[51:0] : {sum[22:0], 29'h0});
        end
    end

    // float to 32-bit integer, rounded by the current mode
    logic signed [12:0] f_e;
    logic [6:0] f_sh;
    logic [84:0] f_shv;
    logic [32:0] f_ip;
    logic f_g;
    logic f_st;
    logic [33:0] f_mag;
    logic [31:0] f_res;
    logic [5:0] f_flg;
    always_comb begin
        f_e = $signed({2'h0, fexp(prec_in, a_in)}) - $signed(bias(prec_in));
        f_sh = 7'(frx_pkg::FRAC_TOP - f_e);
        f_shv = {1'b1, ffrac(prec_in, a_in), 32'h0} >> f_sh;
        f_ip = '0;
        f_g = 1'b0;
        f_st = 1'b0;
        if (f_e < frx_pkg::F2I_LOW) begin
            f_st = 1'b1;
        end else begin
            f_ip = f_shv[64:32];
            f_g = f_shv[31];
            f_st = |f_shv[30:0];
        end
        f_mag = {1'b0, f_ip} + 34'(rnd_up(mode_reg, sa, f_ip[0], f_g, f_st));
        f_res = sa ? (~f_mag[31:0] + 32'h1) : f_mag[31:0];
        f_flg = '0;
        if (ca == frx_pkg::CL_NAN) begin
            f_flg[frx_pkg::FLG_INVALID] = 1'b1;
            f_res = '0;
        end else if (za) begin
            f_res = '0;
        end else if (ca == frx_pkg::CL_INFINITY || f_e > frx_pkg::F2I_TOP ||
                     f_mag > (sa ? frx_pkg::INT_NEG_LIM : frx_pkg::INT_POS_LIM)) begin
            f_flg[frx_pkg::FLG_OVERFLOW] = 1'b1;
            f_res = sa ? frx_pkg::INT_MIN : frx_pkg::INT_MAX;
        end else begin
            f_flg[frx_pkg::FLG_INEXACT] = f_g | f_st;
        end
    end

    // special-case selection per operation
    logic [63:0] res_next;
    logic [5:0] flg_next;
    logic [1:0] cc_next;
    logic cc_upd;
    logic rnd_sel;
    logic bad;
    always_comb begin
        res_next = res_reg;
        flg_next = '0;
        cc_next = cc_reg;
        cc_upd = 1'b0;
        rnd_sel = 1'b0;
        bad = 1'b0;
        if (op_in > frx_pkg::OP_STORE || (read_cycle_in && op_in != frx_pkg::OP_STORE)) begin
            flg_next[frx_pkg::FLG_UNDEF] = 1'b1;
        end else if (op_in == frx_pkg::OP_ADD || op_in == frx_pkg::OP_SUB) begin
            if (nan_any)
                bad = 1'b1;
            else if (ca == frx_pkg::CL_INFINITY && cb == frx_pkg::CL_INFINITY) begin
                bad = (sa != sbe);
                res_next = infinity(prec_in, sa);
            end else if (ca == frx_pkg::CL_INFINITY)
                res_next = infinity(prec_in, sa);
            else if (cb == frx_pkg::CL_INFINITY)
                res_next = infinity(prec_in, sbe);
            else if (za && zb)
                res_next = pack(prec_in, (sa == sbe) ? sa :
                                (mode_reg == frx_pkg::ROUND_TOWARD_MINUS), '0, '0);
            else if (za)
                res_next = pack(prec_in, sbe, {2'h0, fexp(prec_in, b_in)}, ffrac(prec_in, b_in));
            else if (zb)
                res_next = pack(prec_in, sa, {2'h0, fexp(prec_in, a_in)}, ffrac(prec_in, a_in));
            else
                rnd_sel = 1'b1;
        end else if (op_in == frx_pkg::OP_MUL) begin
            if (nan_any || (ca == frx_pkg::CL_INFINITY && zb) ||
                (cb == frx_pkg::CL_INFINITY && za))
                bad = 1'b1;
            else if (ca == frx_pkg::CL_INFINITY || cb == frx_pkg::CL_INFINITY)
                res_next = infinity(prec_in, sx);
            else if (za || zb)
                res_next = pack(prec_in, sx, '0, '0);
            else
                rnd_sel = 1'b1;
        end else if (op_in == frx_pkg::OP_DIV) begin
            if (nan_any || (za && zb) ||
                (ca == frx_pkg::CL_INFINITY && cb == frx_pkg::CL_INFINITY))
                bad = 1'b1;
            else if (ca == frx_pkg::CL_INFINITY)
                res_next = infinity(prec_in, sx);
            else if (cb == frx_pkg::CL_INFINITY || za)
                res_next = pack(prec_in, sx, '0, '0);
            else if (zb) begin
                flg_next[frx_pkg::FLG_DIV0] = 1'b1;
                res_next = infinity(prec_in, sx);
            end else
                rnd_sel = 1'b1;
        end else if (op_in == frx_pkg::OP_CMP) begin
            cc_upd = 1'b1;
            bad = nan_any;
            cc_next = nan_any ? frx_pkg::CC_UNORD :
                      fcmp(sa, sb, za ? '0 : {fexp(prec_in, a_in), ffrac(prec_in, a_in)},
                           zb ? '0 : {fexp(prec_in, b_in), ffrac(prec_in, b_in)});
        end else if (op_in == frx_pkg::OP_I2F) begin
            rnd_sel = 1'b1;
        end else if (op_in == frx_pkg::OP_F2I) begin
            res_next = {32'h0, f_res};
            flg_next = f_flg;
        end
        if (bad && op_in != frx_pkg::OP_CMP) begin
            res_next = nan_val(prec_in);
        end
        if (bad) begin
            flg_next[frx_pkg::FLG_INVALID] = 1'b1;
        end
        if (rnd_sel) begin
            res_next = rnd_val;
            flg_next = rnd_flg;
        end
    end

    // per-operation result
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            res_reg <= '0;
            flg_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= issue_in;
            if (issue_in) begin
                res_reg <= res_next;
                flg_reg <= flg_next;
            end
        end
    end

    // control: rounding mode and enables
    assign ctl_wr = reg_wr_in && reg_addr_in == frx_pkg::REG_PROC_CTRL;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_reg <= frx_pkg::ROUND_NEAREST_EVEN;
            en_reg <= '0;
        end else if (ctl_wr) begin
            mode_reg <= reg_wdata_in[frx_pkg::CTL_MODE_LSB +: 2];
            en_reg <= reg_wdata_in[frx_pkg::CTL_EN_LSB +: frx_pkg::NFLAG];
        end
    end

    // accumulated flags: writing one clears, a new event in the same cycle wins
    always_comb begin
        acc_next = acc_reg &
                   ~(ctl_wr ? reg_wdata_in[frx_pkg::CTL_ACC_LSB +: frx_pkg::NFLAG] : '0);
        if (issue_in) begin
            acc_next = acc_next | flg_next;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            acc_reg <= '0;
            cc_reg <= frx_pkg::CC_EQ;
        end else begin
            acc_reg <= acc_next;
            if (issue_in && cc_upd) begin
                cc_reg <= cc_next;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= '0;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    frx_pkg::REG_PROC_CTRL: begin
                        rdata_reg[frx_pkg::CTL_MODE_LSB +: 2] <= mode_reg;
                        rdata_reg[frx_pkg::CTL_EN_LSB +: frx_pkg::NFLAG] <= en_reg;
                        rdata_reg[frx_pkg::CTL_CC_LSB +: 2] <= cc_reg;
                        rdata_reg[frx_pkg::CTL_ACC_LSB +: frx_pkg::NFLAG] <= acc_reg;
                    end
                    frx_pkg::REG_RES_LO: rdata_reg <= res_reg[31:0];
                    frx_pkg::REG_RES_HI: rdata_reg <= res_reg[63:32];
                    default: rdata_reg <= '0;
                endcase
            end
        end
    end

    // the exception is not tied to the instruction that caused it
    assign exc_irq_out = |(acc_reg & en_reg);
    assign done_out = done_reg;
    assign result_out = res_reg;
    assign op_flags_out = flg_reg;
    assign cond_code_out = cc_reg;
    assign reg_rdata_out = rdata_reg;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_i2s(logic [1:0] m, logic [31:0] v);
        issue_in && op_in == frx_pkg::OP_I2F && !prec_in && !read_cycle_in &&
        mode_reg == m && a_in[31:0] == v;
    endsequence

    sequence s_arith(logic [3:0] o);
        issue_in && !read_cycle_in && op_in == o;
    endsequence

    AST_TIE_EVEN: assert property (s_i2s(frx_pkg::ROUND_NEAREST_EVEN, 32'h7fff_ffc0) |=>
        result_out[31:0] == 32'h4f00_0000 && op_flags_out[frx_pkg::FLG_INEXACT])
        else $error("tie not rounded to even");
    AST_TRUNC: assert property (s_i2s(frx_pkg::ROUND_TOWARD_ZERO, 32'h7fff_ffff) |=>
        result_out[31:0] == 32'h4eff_ffff) else $error("toward zero did not truncate");
    AST_UP: assert property (s_i2s(frx_pkg::ROUND_TOWARD_PLUS, 32'h8000_0040) |=>
        result_out[31:0] == 32'hceff_ffff) else $error("toward plus wrong");
    AST_DOWN: assert property (s_i2s(frx_pkg::ROUND_TOWARD_MINUS, 32'h8000_0040) |=>
        result_out[31:0] == 32'hcf00_0000) else $error("toward minus wrong");
    AST_I2D: assert property (s_arith(frx_pkg::OP_I2F) ##0 prec_in &&
        a_in[31:0] == 32'h8000_0000 |=>
        result_out == 64'hc1e0_0000_0000_0000 && op_flags_out == '0)
        else $error("int to double not exact");
    AST_NAN_IRQ: assert property (s_arith(frx_pkg::OP_ADD) ##0 ca == frx_pkg::CL_NAN &&
        en_reg[frx_pkg::FLG_INVALID] |=> op_flags_out[frx_pkg::FLG_INVALID] &&
        result_out == nan_val($past(prec_in)) ##1 exc_irq_out)
        else $error("nan operand not invalid or no interrupt");
    AST_ZDIV: assert property (s_arith(frx_pkg::OP_DIV) ##0 ca == frx_pkg::CL_NORMAL &&
        zb |=> op_flags_out[frx_pkg::FLG_DIV0] && !op_flags_out[frx_pkg::FLG_INVALID])
        else $error("zero divide not flagged");
    AST_UNDEF: assert property (issue_in && read_cycle_in && op_in != frx_pkg::OP_STORE
        |=> op_flags_out[frx_pkg::FLG_UNDEF] && acc_reg[frx_pkg::FLG_UNDEF])
        else $error("undefined opcode not flagged");
    AST_ACC_HOLD: assert property (!ctl_wr |=>
        (acc_reg & $past(acc_reg)) == $past(acc_reg))
        else $error("accumulated flag lost without clear");
    AST_UNDERFLOW: assert property (s_arith(frx_pkg::OP_ADD) ##0 rnd_sel &&
        !raw_zero_in && raw_exp_in < 0 |=>
        op_flags_out[frx_pkg::FLG_UNDERFLOW] && result_out[30:0] == '0)
        else $error("underflow not flushed");
    AST_OVF_MAX: assert property (s_arith(frx_pkg::OP_ADD) ##0 rnd_sel && prec_in &&
        mode_reg == frx_pkg::ROUND_TOWARD_ZERO && raw_exp_in > 13'sh7ff |=>
        op_flags_out[frx_pkg::FLG_OVERFLOW] && result_out[62:0] == 63'h7fef_ffff_ffff_ffff)
        else $error("overflow result wrong");
endmodule

/* File: bench/frx_host_model.sv */
// host side model: issues one coprocessor instruction at a time
`timescale 1ns/100ps
module frx_host_model (
    // clock
    input wire logic clk_in,
    // instruction issue
    output logic issue_out,
    output logic [3:0] op_out,
    output logic prec_out,
    output logic read_cycle_out,
    output logic [63:0] a_out,
    output logic [63:0] b_out
);
    initial begin
        issue_out = 1'b0;
        op_out = 4'h0;
        prec_out = 1'b0;
        read_cycle_out = 1'b0;
        a_out = 64'h0;
        b_out = 64'h0;
    end
    logic rd_req = 1'b0;
    // operands stay driven after the strobe falls, until the next send, as a real bus would
    task send(input logic [3:0] o, input logic p, input logic [63:0] x, input logic [63:0] y);
        @(posedge clk_in);
        issue_out <= 1'b1;
        read_cycle_out <= rd_req;
        op_out <= o;
        prec_out <= p;
        a_out <= x;
        b_out <= y;
        @(posedge clk_in);
        issue_out <= 1'b0;
        read_cycle_out <= 1'b0;
    endtask
    // the same instruction placed on a read bus cycle
    task send_read(input logic [3:0] o, input logic p, input logic [63:0] x,
                   input logic [63:0] y);
        rd_req = 1'b1;
        send(o, p, x, y);
        rd_req = 1'b0;
    endtask
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the fp result conditioning block
`timescale 1ns/100ps
module testbench;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic issue, prec, rdc, done, irq;
    logic [3:0] op;
    logic [63:0] a, b, res;
    logic [5:0] flg;
    logic [1:0] cc;
    logic [31:0] rdata;
    logic raw_s = 1'b0;
    logic raw_z = 1'b1;
    logic signed [12:0] raw_e = 13'sh000;
    logic [55:0] raw_sig = 56'h0;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    initial begin
        forever #10 mclk_in = ~mclk_in;
    end
    // the unrounded datapath result is preset by set_raw before a normal operation
    frx_round_except dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .issue_in(issue),
        .op_in(op), .prec_in(prec), .read_cycle_in(rdc), .a_in(a), .b_in(b),
        .raw_sign_in(raw_s), .raw_exp_in(raw_e), .raw_sig_in(raw_sig), .raw_zero_in(raw_z),
        .done_out(done), .result_out(res), .op_flags_out(flg), .cond_code_out(cc),
        .exc_irq_out(irq), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata));
    frx_host_model host (.clk_in(mclk_in), .issue_out(issue), .op_out(op), .prec_out(prec),
        .read_cycle_out(rdc), .a_out(a), .b_out(b));
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task do_op(input logic [3:0] o, input logic p, input logic [63:0] x, input logic [63:0] y,
               input logic [63:0] r, input logic [5:0] f);
        host.send(o, p, x, y);
        #1;
        chk("done", {63'h0, done}, 64'h1);
        chk("result", res, r);
        chk("flags", {58'h0, flg}, {58'h0, f});
    endtask
    task set_raw(input logic s, input logic signed [12:0] e, input logic [55:0] m);
        @(posedge mclk_in);
        raw_s <= s;
        raw_z <= 1'b0;
        raw_e <= e;
        raw_sig <= m;
    endtask
    task reg_wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask
    task reg_rd(input logic [3:0] ad, input logic [31:0] e);
        @(posedge mclk_in);
        reg_addr_in <= ad;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk("rdata", {32'h0, rdata}, {32'h0, e});
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles > 2000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        do_op(frx_pkg::OP_I2F, 1'b0, 64'h7fff_ffff, 64'h0, 64'h4f00_0000, 6'h01);
        do_op(frx_pkg::OP_I2F, 1'b1, 64'h8000_0000, '0, 64'hc1e0_0000_0000_0000, 6'h00);
        do_op(frx_pkg::OP_ADD, 1'b0, 64'h7fc0_0000, 64'h3f80_0000, 64'h7fff_ffff, 6'h10);
        do_op(frx_pkg::OP_DIV, 1'b0, 64'h3f80_0000, 64'h0, 64'h7f80_0000, 6'h08);
        do_op(frx_pkg::OP_CMP, 1'b0, 64'h7fc0_0000, 64'h0, 64'h7f80_0000, 6'h10);
        chk("cond", {62'h0, cc}, {62'h0, frx_pkg::CC_UNORD});
        do_op(4'h8, 1'b0, 64'h0, 64'h0, 64'h7f80_0000, 6'h20);
        reg_wr(frx_pkg::REG_PROC_CTRL, 32'h0000_0003);
        do_op(frx_pkg::OP_ADD, 1'b0, 64'h0, 64'h8000_0000, 64'h8000_0000, 6'h00);
        reg_rd(frx_pkg::REG_PROC_CTRL, 32'h3903_0003);
        reg_wr(frx_pkg::REG_PROC_CTRL, 32'h0000_1003);
        chk("irq", {63'h0, irq}, 64'h1);
        reg_wr(frx_pkg::REG_PROC_CTRL, 32'h3f00_1003);
        chk("irq", {63'h0, irq}, 64'h0);
        reg_rd(frx_pkg::REG_PROC_CTRL, 32'h0003_1003);
        do_op(frx_pkg::OP_ADD, 1'b0, 64'h7fc0_0000, 64'h3f80_0000, 64'h7fff_ffff, 6'h10);
        chk("irq", {63'h0, irq}, 64'h1);
        do_op(frx_pkg::OP_SUB, 1'b0, 64'h7f80_0000, 64'h7f80_0000, 64'h7fff_ffff, 6'h10);
        set_raw(1'b1, -13'sh002, 56'h80_0000_0000_0000);
        do_op(frx_pkg::OP_ADD, 1'b0, 64'h3f80_0000, 64'h3f80_0000, 64'h8000_0000, 6'h02);
        reg_wr(frx_pkg::REG_PROC_CTRL, 32'h0000_1001);
        do_op(frx_pkg::OP_I2F, 1'b0, 64'h7fff_ffff, 64'h0, 64'h4eff_ffff, 6'h01);
        set_raw(1'b0, 13'sh800, 56'h80_0000_0000_0000);
        do_op(frx_pkg::OP_ADD, 1'b1, 64'h10_0000_0000_0000, 64'h10_0000_0000_0000,
              64'h7fef_ffff_ffff_ffff, 6'h05);
        reg_rd(frx_pkg::REG_RES_HI, 32'h7fef_ffff);
        reg_rd(frx_pkg::REG_RES_LO, 32'hffff_ffff);
        reg_wr(frx_pkg::REG_PROC_CTRL, 32'h0000_1002);
        do_op(frx_pkg::OP_I2F, 1'b0, 64'h8000_0040, 64'h0, 64'hceff_ffff, 6'h01);
        reg_wr(frx_pkg::REG_PROC_CTRL, 32'h0000_1003);
        do_op(frx_pkg::OP_I2F, 1'b0, 64'h8000_0040, 64'h0, 64'hcf00_0000, 6'h01);
        reg_wr(frx_pkg::REG_PROC_CTRL, 32'h0000_1000);
        do_op(frx_pkg::OP_I2F, 1'b0, 64'h7fff_ffc0, 64'h0, 64'h4f00_0000, 6'h01);
        do_op(frx_pkg::OP_F2I, 1'b0, 64'h3fc0_0000, 64'h0, 64'h2, 6'h01);
        do_op(frx_pkg::OP_F2I, 1'b0, 64'h4f00_0000, 64'h0, 64'h7fff_ffff, 6'h04);
        host.send_read(frx_pkg::OP_MUL, 1'b0, 64'h3f80_0000, 64'h3f80_0000);
        #1;
        chk("flags", {58'h0, flg}, 64'h20);
        chk("result", res, 64'h7fff_ffff);
        reg_rd(4'hf, 32'h0);
        complete_run();
    end
endmodule
